// [hdl/gtmr_map.svh]
// Register offsets, field positions, reset values and timing counts.
// Behaviour
// - Counter bytes are read separately with no latch, so the two bytes can come from different counts.
// - Gate enable hands counting to the gate.
// - Count only when gate level matches polarity.
// - Source select: pin, wrap pulse, comparator, reserved.
// - Companion timer wrap makes a gate pulse.
// - Toggle mode flips gate on rising edges.
// - Toggle flip-flop held clear while mode off.
// - Single pulse: count once, clear go after.
// - Toggle plus single pulse measure one cycle.
// - Gate value status shows the gate after polarity, or the single pulse window in single pulse mode.
// - Gate falling edge sets event flag, interrupt.
// - Counter wraps FFFF to 0000, sets flag.
// - Overflow interrupt needs four enables all set.
// - Sleep counting and wake only asynchronous external.
// - Wake continues; vectors when global enable set.
// - External counting needs a falling edge first.
// - Timer off stops counting, clears gate flip-flop.
`ifndef GTMR_MAP_SVH
`define GTMR_MAP_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// -----------------------------------------------------------------------------
`define GT_OFF_CNT_LO   8'h00
`define GT_OFF_CNT_HI   8'h04
`define GT_OFF_TCTRL    8'h08
`define GT_OFF_GCTRL    8'h0C
`define GT_OFF_FLAGS    8'h10
`define GT_OFF_ENABLES  8'h14
`define GT_OFF_IRQCTL   8'h18

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define GT_TC_ON        0
`define GT_TC_SYNC      2
`define GT_TC_PS_LO     4
`define GT_TC_CS_LO     6
`define GT_GC_SS_LO     0
`define GT_GC_VAL       2
`define GT_GC_GO        3
`define GT_GC_SPM       4
`define GT_GC_TM        5
`define GT_GC_POL       6
`define GT_GC_GE        7
`define GT_FL_OVF       0
`define GT_FL_GATE      7
`define GT_IC_PERIPHERAL_IRQ_ENABLE      6
`define GT_IC_GIE       7

// -----------------------------------------------------------------------------
// Writable masks and reset values
// -----------------------------------------------------------------------------
`define GT_TC_WMASK     8'hF5
`define GT_GC_WMASK     8'hF3
`define GT_EN_WMASK     8'h81
`define GT_IC_WMASK     8'hC0
`define GT_RST_BYTE     8'h00

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define GT_CLK_KHZ      125000
`define GT_LF_KHZ       31
`define GT_LF_DIV       (`GT_CLK_KHZ / `GT_LF_KHZ)
`define GT_INSTR_DIV    4

`endif

// [hdl/gtmr_pkg.sv]
// Types shared by the gated sixteen-bit timer.
package gtmr_pkg;

    typedef enum logic [1:0] {
        GT_CS_INSTR = 2'h0,
        GT_CS_SYS   = 2'h1,
        GT_CS_EXT   = 2'h2,
        GT_CS_LF    = 2'h3
    } gtmr_clk_src_t;

    typedef enum logic [1:0] {
        GT_GS_PIN   = 2'h0,
        GT_GS_WRAP  = 2'h1,
        GT_GS_CMP   = 2'h2,
        GT_GS_RSVD  = 2'h3
    } gtmr_gate_src_t;

    typedef enum logic [2:0] {
        GT_SP_IDLE  = 3'h1,
        GT_SP_ARMED = 3'h2,
        GT_SP_RUN   = 3'h4
    } gtmr_sp_state_t;

endpackage

// [hdl/gtmr_sync.sv]
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ns
module gtmr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// [hdl/gtmr_top.sv]
// Gated sixteen-bit timer with Wishbone register access.
`timescale 1ns/1ns
`include "gtmr_map.svh"
module gtmr_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        timer_clock_pin_i,
    input  wire logic        gate_pin_i,
    input  wire logic        comparator_one_output_i,
    input  wire logic [7:0]  companion_count_i,
    input  wire logic        sleep_i,
    output logic             irq_o,
    output logic             wake_o
);
    import gtmr_pkg::*;

    // -------------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------------
    logic [15:0]    cnt_q;
    logic [7:0]     tctrl_q;
    logic [7:0]     gctrl_q;
    logic [7:0]     en_q;
    logic [7:0]     ic_q;
    logic           ovf_flag_q;
    logic           gate_flag_q;
    logic           ack_q;
    logic [31:0]    rdat_q;
    logic           irq_q;
    logic           wake_q;
    gtmr_sp_state_t sp_q;
    gtmr_sp_state_t sp_d;

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    wire req     = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr      = req & wb_we_i & wb_sel_i[0];
    wire [7:0] wdat = wb_dat_i[7:0];
    wire wr_lo   = wr & (wb_adr_i == `GT_OFF_CNT_LO);
    wire wr_hi   = wr & (wb_adr_i == `GT_OFF_CNT_HI);
    wire wr_tc   = wr & (wb_adr_i == `GT_OFF_TCTRL);
    wire wr_gc   = wr & (wb_adr_i == `GT_OFF_GCTRL);
    wire wr_fl   = wr & (wb_adr_i == `GT_OFF_FLAGS);
    wire wr_en   = wr & (wb_adr_i == `GT_OFF_ENABLES);
    wire wr_ic   = wr & (wb_adr_i == `GT_OFF_IRQCTL);
    wire cnt_wr  = wr_lo | wr_hi;

    // -------------------------------------------------------------------------
    // Control fields
    // -------------------------------------------------------------------------
    wire timer_on   = tctrl_q[`GT_TC_ON];
    wire sync_bypass = tctrl_q[`GT_TC_SYNC];
    wire [1:0] prescale = tctrl_q[`GT_TC_PS_LO+1:`GT_TC_PS_LO];
    wire [1:0] clock_source_select = tctrl_q[`GT_TC_CS_LO+1:`GT_TC_CS_LO];
    wire gate_enable    = gctrl_q[`GT_GC_GE];
    wire gate_polarity  = gctrl_q[`GT_GC_POL];
    wire gate_toggle_mode = gctrl_q[`GT_GC_TM];
    wire gate_single_pulse_mode = gctrl_q[`GT_GC_SPM];
    wire [1:0] gate_source_select = gctrl_q[`GT_GC_SS_LO+1:`GT_GC_SS_LO];
    wire ext_sel = (clock_source_select == GT_CS_EXT);

    // -------------------------------------------------------------------------
    // Clock source ticks and prescaler
    // -------------------------------------------------------------------------
    logic [1:0]  instr_cnt_q;
    logic [11:0] lf_cnt_q;
    logic        ext_q;
    logic        fall_seen_q;
    logic [2:0]  presc_q;

    wire instr_tick = (instr_cnt_q == 2'(`GT_INSTR_DIV - 1));
    wire lf_tick    = (lf_cnt_q == 12'(`GT_LF_DIV - 1));
    wire ext_rise   = timer_clock_pin_i & ~ext_q;
    wire ext_fall   = ~timer_clock_pin_i & ext_q;
    wire src_tick   = (clock_source_select == GT_CS_INSTR) ? instr_tick :
                      (clock_source_select == GT_CS_SYS)   ? 1'b1 :
                      (clock_source_select == GT_CS_EXT)   ? ext_rise :
                                                             lf_tick;
    wire [2:0] ps_mask = (prescale == 2'h0) ? 3'h0 :
                         (prescale == 2'h1) ? 3'h1 :
                         (prescale == 2'h2) ? 3'h3 : 3'h7;
    wire tick = src_tick & ((presc_q & ps_mask) == ps_mask);

    // External counting waits for a falling edge after arming.
    wire ext_ready = ~ext_sel | fall_seen_q;
    // In sleep only the unsynchronised external source keeps running.
    wire sleep_ok  = ~sleep_i | (ext_sel & sync_bypass);

    // -------------------------------------------------------------------------
    // Gate path
    // -------------------------------------------------------------------------
    logic [1:0] gate_sync;
    logic       wrap_q;
    logic [7:0] comp_prev_q;
    logic       tff_q;
    logic       src_q;
    logic       pol_q;
    logic       gval_q;

    // Pin and comparator are asynchronous, so they are resynchronised.
    gtmr_sync #(
        .W (2)
    ) u_gate_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({comparator_one_output_i, gate_pin_i}),
        .q_o   (gate_sync)
    );

    // A wrap of the companion timer from FF to 00 gives a one-cycle pulse.
    wire wrap_evt = (comp_prev_q == 8'hFF) & (companion_count_i == 8'h00);
    wire src_raw = (gate_source_select == GT_GS_PIN)  ? gate_sync[0] :
                   (gate_source_select == GT_GS_WRAP) ? wrap_q :
                   (gate_source_select == GT_GS_CMP)  ? gate_sync[1] :
                                                        1'b0;
    wire src_rise = src_raw & ~src_q;
    wire tg       = gate_toggle_mode ? tff_q : src_raw;
    // High when the gate level matches the polarity.
    wire pol_gate = ~(tg ^ gate_polarity);
    wire pol_rise = pol_gate & ~pol_q;
    wire pol_fall = ~pol_gate & pol_q;
    wire sp_run   = (sp_q == GT_SP_RUN);
    // Combining toggle and single pulse yields one full source cycle.
    wire gate_ctrl = gate_single_pulse_mode ? sp_run : pol_gate;
    wire gate_fall = ~gate_ctrl & gval_q;
    wire go_done  = (sp_q != GT_SP_IDLE);

    always_comb
    begin
        sp_d = sp_q;
        unique case (sp_q)
            GT_SP_IDLE:
                if (wr_gc & wdat[`GT_GC_GO])
                    sp_d = GT_SP_ARMED;
            GT_SP_ARMED:
                if (wr_gc & ~wdat[`GT_GC_GO])
                    sp_d = GT_SP_IDLE;
                else if (gate_single_pulse_mode & pol_rise)
                    sp_d = GT_SP_RUN;
            GT_SP_RUN:
                if (wr_gc & ~wdat[`GT_GC_GO])
                    sp_d = GT_SP_IDLE;
                else if (gate_single_pulse_mode & pol_fall)
                    sp_d = GT_SP_IDLE;
            default:
                sp_d = GT_SP_IDLE;
        endcase
    end

    // -------------------------------------------------------------------------
    // Counter
    // -------------------------------------------------------------------------
    // Gate enable matters only while the timer runs.
    wire cnt_open = timer_on & (~gate_enable | gate_ctrl);
    // A counter write wins over an increment in the same cycle.
    wire inc      = cnt_open & tick & ext_ready & sleep_ok & ~cnt_wr;
    wire ovf_evt  = inc & (cnt_q == 16'hFFFF);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            instr_cnt_q <= 2'h0;
            lf_cnt_q    <= 12'h000;
            ext_q       <= 1'b0;
            presc_q     <= 3'h0;
            fall_seen_q <= 1'b0;
            cnt_q       <= 16'h0000;
        end
        else
        begin
            instr_cnt_q <= instr_tick ? 2'h0 : instr_cnt_q + 2'h1;
            lf_cnt_q    <= lf_tick ? 12'h000 : lf_cnt_q + 12'h001;
            ext_q       <= timer_clock_pin_i;
            if (cnt_wr | ~timer_on)
                presc_q <= 3'h0;
            else if (src_tick & cnt_open)
                presc_q <= presc_q + 3'h1;
            if (cnt_wr | ~timer_on)
                fall_seen_q <= 1'b0;
            else if (ext_fall)
                fall_seen_q <= 1'b1;
            if (wr_lo)
                cnt_q[7:0] <= wdat;
            else if (wr_hi)
                cnt_q[15:8] <= wdat;
            else if (inc)
                cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            comp_prev_q <= 8'h00;
            wrap_q      <= 1'b0;
            src_q       <= 1'b0;
            pol_q       <= 1'b0;
            gval_q      <= 1'b0;
            tff_q       <= 1'b0;
            sp_q        <= GT_SP_IDLE;
        end
        else
        begin
            comp_prev_q <= companion_count_i;
            wrap_q      <= wrap_evt;
            src_q       <= src_raw;
            pol_q       <= pol_gate;
            gval_q      <= gate_ctrl;
            if (~gate_toggle_mode | ~timer_on)
                tff_q <= 1'b0;
            else if (src_rise)
                tff_q <= ~tff_q;
            sp_q <= sp_d;
        end
    end

    // -------------------------------------------------------------------------
    // Registers and flags
    // -------------------------------------------------------------------------
    // Hardware setting a flag wins over a software clear in the same cycle.
    wire ovf_flag_d  = ovf_evt |
                       (wr_fl ? wdat[`GT_FL_OVF] : ovf_flag_q);
    wire gate_flag_d = gate_fall |
                       (wr_fl ? wdat[`GT_FL_GATE] : gate_flag_q);
    wire peripheral_irq_enable = ic_q[`GT_IC_PERIPHERAL_IRQ_ENABLE];
    wire global_irq_enable  = ic_q[`GT_IC_GIE];
    wire ovf_irq  = ovf_flag_q & en_q[`GT_FL_OVF] & timer_on;
    wire gate_irq = gate_flag_q & en_q[`GT_FL_GATE];
    wire irq_d    = global_irq_enable & peripheral_irq_enable & (ovf_irq | gate_irq);
    wire wake_d   = sleep_i & ovf_irq & peripheral_irq_enable & sync_bypass & ext_sel;

    // Each counter byte has its own word and no latch, so the two bytes may come from different counts.
    wire [7:0] rd_byte =
        (wb_adr_i == `GT_OFF_CNT_LO)  ? cnt_q[7:0] :
        (wb_adr_i == `GT_OFF_CNT_HI)  ? cnt_q[15:8] :
        (wb_adr_i == `GT_OFF_TCTRL)   ? tctrl_q :
        (wb_adr_i == `GT_OFF_GCTRL)   ?
            {gctrl_q[7:4], go_done, gate_ctrl, gctrl_q[1:0]} :
        (wb_adr_i == `GT_OFF_FLAGS)   ?
            {gate_flag_q, 6'h00, ovf_flag_q} :
        (wb_adr_i == `GT_OFF_ENABLES) ? en_q :
        (wb_adr_i == `GT_OFF_IRQCTL)  ? ic_q : 8'h00;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tctrl_q     <= `GT_RST_BYTE;
            gctrl_q     <= `GT_RST_BYTE;
            en_q        <= `GT_RST_BYTE;
            ic_q        <= `GT_RST_BYTE;
            ovf_flag_q  <= 1'b0;
            gate_flag_q <= 1'b0;
            ack_q       <= 1'b0;
            rdat_q      <= 32'h00000000;
            irq_q       <= 1'b0;
            wake_q      <= 1'b0;
        end
        else
        begin
            if (wr_tc)
                tctrl_q <= wdat & `GT_TC_WMASK;
            if (wr_gc)
                gctrl_q <= wdat & `GT_GC_WMASK;
            if (wr_en)
                en_q <= wdat & `GT_EN_WMASK;
            if (wr_ic)
                ic_q <= wdat & `GT_IC_WMASK;
            ovf_flag_q  <= ovf_flag_d;
            gate_flag_q <= gate_flag_d;
            ack_q       <= req;
            if (req)
                rdat_q <= {24'h000000, rd_byte};
            irq_q  <= irq_d;
            wake_q <= wake_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o    = irq_q;
    assign wake_o   = wake_q;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_count_step: assert property (
        inc |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not step by one");
    a_hold_closed: assert property (
        (timer_on & gate_enable & ~gate_ctrl & ~cnt_wr) |=> $stable(cnt_q))
        else $error("counter moved with gate closed");
    a_rsvd_source: assert property (
        (gate_source_select == GT_GS_RSVD) |-> ~src_raw)
        else $error("reserved gate source not quiet");
    a_toggle_clear: assert property (
        (~gate_toggle_mode | ~timer_on) |=> ~tff_q)
        else $error("toggle flip-flop not held clear");
    a_pulse_done: assert property (
        (sp_run & gate_single_pulse_mode & pol_fall & ~wr_gc)
        |=> sp_q == GT_SP_IDLE ##1 sp_q == GT_SP_IDLE || $past(wr_gc))
        else $error("go bit not cleared at trailing edge");
    a_gate_flag: assert property (
        gate_fall |=> gate_flag_q)
        else $error("gate fall lost its flag");
    a_wrap_flag: assert property (
        ovf_evt |=> ovf_flag_q && cnt_q == 16'h0000)
        else $error("rollover did not set flag");
    a_off_stops: assert property (
        (~timer_on & ~cnt_wr) |=> $stable(cnt_q) && ~tff_q)
        else $error("timer off but counter moved");
    a_first_fall: assert property (
        (ext_sel & ~fall_seen_q) |-> ~inc)
        else $error("external count before falling edge");
    a_wake_out: assert property (
        wake_d |=> wake_o)
        else $error("wake not raised");
endmodule

// [sim/gtmr_far_side.sv]
// Model of the gate pin, comparator, companion timer and count clock pin.
`timescale 1ns/1ns
module gtmr_far_side (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       gate_cmd_i,
    input  wire logic       cmp_cmd_i,
    input  wire logic       wrap_run_i,
    input  wire logic       ext_run_i,
    output logic            gate_pin_o,
    output logic            cmp_o,
    output logic      [7:0] count_o,
    output logic            ext_clk_o
);
    logic [1:0] div_q;

    // The count clock stands low between runs, so every run opens with a
    // rising edge that the counter has to ignore.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gate_pin_o <= 1'b0;
            cmp_o      <= 1'b0;
            count_o    <= 8'h00;
            ext_clk_o  <= 1'b0;
            div_q      <= 2'h0;
        end
        else
        begin
            gate_pin_o <= gate_cmd_i;
            cmp_o      <= cmp_cmd_i;
            if (wrap_run_i)
                count_o <= count_o + 8'h01;
            div_q     <= ext_run_i ? div_q + 2'h1 : 2'h0;
            ext_clk_o <= ext_run_i ? (ext_clk_o ^ (div_q == 2'h3)) : 1'b0;
        end
    end
endmodule

// [sim/gtmr_tb_top.sv]
// Self-checking bench for the gated sixteen-bit timer.
`timescale 1ns/1ns
`include "gtmr_map.svh"
module gtmr_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, irq_o, wake_o, ext_clk, gpin, cmp, sleep = 1'b0;
    logic        gate_cmd = 1'b0, cmp_cmd = 1'b0;
    logic        wrap_run = 1'b0, ext_run = 1'b0;
    logic [7:0]  ccount;
    logic [31:0] q;
    logic [15:0] a, b;
    int          err_count = 0;
    int          samples_checked = 0;

    always #4 clk_i = ~clk_i;

    gtmr_top gtmr_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_clock_pin_i(ext_clk), .gate_pin_i(gpin),
        .comparator_one_output_i(cmp), .companion_count_i(ccount),
        .sleep_i(sleep), .irq_o(irq_o), .wake_o(wake_o));

    gtmr_far_side gtmr_far_side_i (.clk_i(clk_i), .rst_i(rst_i),
        .gate_cmd_i(gate_cmd), .cmp_cmd_i(cmp_cmd), .wrap_run_i(wrap_run),
        .ext_run_i(ext_run), .gate_pin_o(gpin), .cmp_o(cmp),
        .count_o(ccount), .ext_clk_o(ext_clk));

    // -------------------------------------------------------------------
    // Bus, comparison and closing tasks
    // -------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] ad,
                        input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; sel <= s;
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n == 50) chk("bus answer", 32'h0, 32'h1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        xfer(1'b1, ad, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] ad);
        xfer(1'b0, ad, 8'h00, 4'hF);
    endtask

    task automatic cnt(output logic [15:0] v);
        rd(`GT_OFF_CNT_LO);
        v[7:0] = q[7:0];
        rd(`GT_OFF_CNT_HI);
        v[15:8] = q[7:0];
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic pulse(input int hi, input int lo);
        @(posedge clk_i) gate_cmd <= 1'b1;
        wt(hi);
        gate_cmd <= 1'b0;
        wt(lo);
    endtask

    // Timer stopped before the count is written; toggle and single-pulse mode are set
    // together in a write of their own, after polarity and source, and go is left clear.
    task automatic setup(input logic [7:0] gc);
        wr(`GT_OFF_TCTRL, 8'h00);
        wr(`GT_OFF_CNT_LO, 8'h00);
        wr(`GT_OFF_CNT_HI, 8'h00);
        wr(`GT_OFF_FLAGS, 8'h00);
        wr(`GT_OFF_GCTRL, gc & 8'hC7);
        wr(`GT_OFF_GCTRL, gc & 8'hF7);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 8; i++)
        begin
            rd(8'(i * 4));
            // A low gate with low polarity is an open gate, so the gate
            // value status reads one straight out of reset.
            chk("reset value", q, (i == 3) ? 32'h4 : 32'h0);
        end
        xfer(1'b1, `GT_OFF_GCTRL, 8'hC3, 4'hE);
        rd(`GT_OFF_GCTRL);
        chk("lane refused", q, 32'h4);
        wr(8'h1C, 8'hFF);
        rd(8'h1C);
        chk("unmapped", q, 32'h0);
    endtask

    task automatic t_gate_level;
        setup(8'hC0);
        wr(`GT_OFF_TCTRL, 8'h41);
        wt(10);
        cnt(a);
        chk("held count", a, 16'h0);
        pulse(10, 4);
        cnt(a);
        cnt(b);
        chk("gated count", a != 0 && a == b, 1'b1);
        wr(`GT_OFF_GCTRL, 8'h80);
        cnt(a);
        cnt(b);
        chk("low polarity", b != a, 1'b1);
    endtask

    task automatic t_single;
        setup(8'hD0);
        wr(`GT_OFF_TCTRL, 8'h41);
        wr(`GT_OFF_GCTRL, 8'hD8);
        rd(`GT_OFF_GCTRL);
        chk("armed", q[3], 1'b1);
        pulse(6, 10);
        rd(`GT_OFF_GCTRL);
        chk("done", q[3], 1'b0);
        cnt(a);
        pulse(6, 10);
        cnt(b);
        chk("one pulse", a != 0 && a == b, 1'b1);
        wr(`GT_OFF_GCTRL, 8'hC0);
        rd(`GT_OFF_GCTRL);
        chk("go cleared", q[3], 1'b0);
    endtask

    task automatic t_toggle;
        setup(8'hF0);
        wr(`GT_OFF_TCTRL, 8'h41);
        wr(`GT_OFF_GCTRL, 8'hF8);
        pulse(4, 8);
        pulse(4, 8);
        wt(8);
        rd(`GT_OFF_GCTRL);
        chk("cycle done", q[3], 1'b0);
        cnt(a);
        chk("full cycle", a > 8 && a < 16, 1'b1);
        setup(8'hE0);
        wr(`GT_OFF_TCTRL, 8'h41);
        pulse(4, 8);
        cnt(a);
        cnt(b);
        chk("toggled on", b != a, 1'b1);
        wr(`GT_OFF_TCTRL, 8'h40);
        wr(`GT_OFF_TCTRL, 8'h41);
        cnt(a);
        cnt(b);
        chk("off clears", b, a);
        pulse(4, 8);
        wr(`GT_OFF_GCTRL, 8'hC0);
        cnt(a);
        cnt(b);
        chk("toggle cleared", b, a);
    endtask

    task automatic t_status;
        setup(8'h40);
        @(posedge clk_i) gate_cmd <= 1'b1;
        wt(6);
        rd(`GT_OFF_GCTRL);
        chk("gate value", q[2], 1'b1);
        wr(`GT_OFF_FLAGS, 8'h00);
        wr(`GT_OFF_ENABLES, 8'h80);
        wr(`GT_OFF_IRQCTL, 8'hC0);
        @(posedge clk_i) gate_cmd <= 1'b0;
        wt(6);
        rd(`GT_OFF_FLAGS);
        chk("gate event", q[7], 1'b1);
        chk("gate irq", irq_o, 1'b1);
        wr(`GT_OFF_GCTRL, 8'h42);
        @(posedge clk_i) cmp_cmd <= 1'b1;
        wt(6);
        rd(`GT_OFF_GCTRL);
        chk("comparator", q[2], 1'b1);
        wr(`GT_OFF_GCTRL, 8'h43);
        wt(6);
        rd(`GT_OFF_GCTRL);
        chk("reserved", q[2], 1'b0);
        wr(`GT_OFF_GCTRL, 8'h41);
        wt(4);
        wr(`GT_OFF_FLAGS, 8'h00);
        @(posedge clk_i) wrap_run <= 1'b1;
        wt(200);
        rd(`GT_OFF_FLAGS);
        chk("no wrap yet", q[7], 1'b0);
        wt(100);
        rd(`GT_OFF_FLAGS);
        chk("wrap pulse", q[7], 1'b1);
        wrap_run <= 1'b0;
    endtask

    task automatic t_overflow;
        setup(8'h00);
        wr(`GT_OFF_CNT_HI, 8'hFF);
        wr(`GT_OFF_CNT_LO, 8'hF0);
        wr(`GT_OFF_ENABLES, 8'h01);
        wr(`GT_OFF_IRQCTL, 8'hC0);
        wr(`GT_OFF_TCTRL, 8'h41);
        wt(30);
        rd(`GT_OFF_FLAGS);
        chk("overflow flag", q[0], 1'b1);
        chk("overflow irq", irq_o, 1'b1);
        rd(`GT_OFF_CNT_HI);
        chk("rolled over", q, 32'h0);
        wr(`GT_OFF_IRQCTL, 8'h40);
        wt(2);
        chk("global off", irq_o, 1'b0);
        wr(`GT_OFF_FLAGS, 8'h00);
        rd(`GT_OFF_FLAGS);
        chk("flag cleared", q[0], 1'b0);
        wr(`GT_OFF_TCTRL, 8'h40);
        cnt(a);
        cnt(b);
        chk("stopped", b, a);
    endtask

    task automatic t_wake;
        setup(8'h00);
        wr(`GT_OFF_CNT_HI, 8'hFF);
        wr(`GT_OFF_CNT_LO, 8'hFE);
        wr(`GT_OFF_ENABLES, 8'h01);
        wr(`GT_OFF_IRQCTL, 8'h40);
        sleep <= 1'b1;
        wr(`GT_OFF_TCTRL, 8'h85);
        ext_run <= 1'b1;
        wt(60);
        chk("wake", wake_o, 1'b1);
        chk("no vector", irq_o, 1'b0);
        wr(`GT_OFF_IRQCTL, 8'hC0);
        wt(2);
        chk("vector", irq_o, 1'b1);
        ext_run <= 1'b0;
        sleep <= 1'b0;
    endtask

    initial
    begin
        wt(2);
        rst_i <= 1'b0;
        t_reset();
        t_gate_level();
        t_single();
        t_toggle();
        t_status();
        t_overflow();
        t_wake();
        summarize();
    end

    initial
    begin
        #200000;
        err_count++;
        summarize();
    end
endmodule
